// ===== rtl/scc_pkg.sv
// Package of the smart card serial channel control and status block.
// Assumes an AXI4-Lite master with 32-bit data and one 100 MHz clock.
//
// Functional notes
// - Transmit-empty interrupt leaves only while control bit 7 is 1.
// - Receive-full and receive-fault interrupts leave only while control bit 6 is 1.
// - Serial transmission runs only while control bit 5 is 1.
// - Serial reception runs only while control bit 4 is 1.
// - Block-output mode 0: 00 frees pin, 01 drives clock, 1X reserved.
// - Block-output mode 1: 00 low, 10 high, 01 and 11 drive clock.
// - Clock select rewrites take effect during operation in block-output mode.
// - Writing 1 to status flags is ignored; software can only clear them.
// - Transmit-empty sets while transmit disabled or when holding moves to shift.
// - Transmit-empty clears by 0 after read 1, or engine writing holding.
// - Receive-full sets when an error-free character moves into holding.
// - Receive-full clears by 0 after read 1, or engine reading holding.
// - Clearing receive enable leaves receive-full unchanged.
// - Transmit-empty is status bit 7 and reads 1 after reset.
// - Overrun sets when a reception completes while receive-full is 1.
package scc_pkg;

  // Register byte offsets.
  localparam logic [4:0] CTRL_OFS   = 5'h00;
  localparam logic [4:0] STATUS_OFS = 5'h04;
  localparam logic [4:0] MODE_OFS   = 5'h08;
  localparam logic [4:0] TXDATA_OFS = 5'h0c;
  localparam logic [4:0] RXDATA_OFS = 5'h10;

  // Control register fields.
  localparam int TX_EMPTY_IRQ_ENABLE = 7;
  localparam int RX_IRQ_ENABLE       = 6;
  localparam int TX_ENABLE_BIT       = 5;
  localparam int RX_ENABLE_BIT       = 4;
  localparam int CLOCK_SEL_HI        = 1;
  localparam int CLOCK_SEL_LO        = 0;
  localparam logic [7:0] CTRL_RESET  = 8'h00;

  // Mode register fields.
  localparam int CARD_MODE_SELECT    = 0;
  localparam int BLOCK_OUTPUT_MODE   = 1;
  localparam int MULTIDROP_FORMAT    = 2;
  localparam logic [2:0] MODE_RESET  = 3'h0;

  // Status register fields.
  localparam int TX_HOLDING_EMPTY    = 7;
  localparam int RX_HOLDING_FULL     = 6;
  localparam int OVERRUN_FAULT       = 5;
  localparam int FRAME_FAULT         = 4;
  localparam int PARITY_FAULT        = 3;
  localparam logic [7:0] FLAG_MASK   = 8'hf8;
  localparam logic [7:0] STATUS_RESET = 8'h80;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== rtl/scc_sync.sv
// Two-stage synchroniser for a single pin level.
// Assumes the input is asynchronous to clock.
`timescale 1ns/1ps
module scc_sync
(
  // Clock and reset.
  input  wire logic clock,
  input  wire logic nrst,
  // Level in and out.
  input  wire logic pinIn,
  output logic      syncOut
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } scc_sync_state_type;

  scc_sync_state_type state;
  scc_sync_state_type next_state;

  // The first stage feeds only the second stage.
  always_comb
  begin
    next_state.stage1 = pinIn;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      state <= '0;
    else
      state <= next_state;
  end

  assign syncOut = state.stage2;

endmodule

// ===== rtl/scc_clk_out.sv
// Clock pin driver: decodes the clock select bits into level and enable.
// Assumes runClk is already synchronised to clock.
`timescale 1ns/1ps
module scc_clk_out
(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       nrst,
  // Selection.
  input  wire logic       cardMode,
  input  wire logic       blockMode,
  input  wire logic [1:0] clockSel,
  input  wire logic       runClk,
  // Pin.
  output logic            pinOut,
  output logic            pinOe
);

  typedef struct packed {
    logic level;
    logic enable;
  } scc_clk_state_type;

  scc_clk_state_type state;
  scc_clk_state_type next_state;

  // The select bits are read live and registered, so rewrites switch the pin one clock later.
  always_comb
  begin
    next_state = '0;
    if (cardMode && blockMode)
    begin
      next_state.enable = 1'b1;
      if (clockSel[0])
        next_state.level = runClk;
      else
        next_state.level = clockSel[1];
    end
    else if (clockSel == 2'h1)
    begin
      next_state.enable = 1'b1;
      next_state.level  = runClk;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      state <= '0;
    else
      state <= next_state;
  end

  assign pinOut = state.level;
  assign pinOe  = state.enable;

endmodule

// ===== rtl/scc_card_ctrl.sv
// Control register, status flags and interrupt requests of the serial channel.
// Assumes shift engines and a transfer engine on the same clock; the running
// serial clock arrives from outside the clock domain.
`timescale 1ns/1ps
module scc_card_ctrl
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        nrst,
  // AXI4-Lite write address.
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [4:0]  awaddr,
  // AXI4-Lite write data.
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // AXI4-Lite write response.
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read address.
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [4:0]  araddr,
  // AXI4-Lite read data.
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Transmit engine.
  output logic             txEnable,
  output logic [7:0]       txData,
  input  wire logic        txLoad,
  // Receive engine.
  output logic             rxEnable,
  input  wire logic        rxDone,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxParityErr,
  input  wire logic        rxFrameErr,
  // Transfer engine.
  input  wire logic        engineTxWrite,
  input  wire logic [7:0]  engineTxData,
  input  wire logic        engineRxRead,
  // Interrupt requests.
  output logic             txEmptyIrq,
  output logic             rxFullIrq,
  output logic             rxFaultIrq,
  // Clock pin.
  input  wire logic        serialClkIn,
  output logic             sckOut,
  output logic             sckOe
);

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [2:0]  mode;
    logic [7:0]  txHold;
    logic [7:0]  rxHold;
    logic [7:0]  flags;
    logic [7:0]  seen;
    logic        awHave;
    logic [4:0]  awAddr;
    logic        wHave;
    logic [7:0]  wData;
    logic        wLane;
    logic        awReady;
    logic        wReady;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [7:0]  rData;
    logic [1:0]  rResp;
    logic        txIrq;
    logic        rxIrq;
    logic        faultIrq;
  } scc_ctrl_state_type;

  scc_ctrl_state_type state;
  scc_ctrl_state_type next_state;
  logic               runClk;

  // Returns true when the offset names a register.
  function automatic logic isMapped(input logic [4:0] ofs);
    isMapped = (ofs == scc_pkg::CTRL_OFS) || (ofs == scc_pkg::STATUS_OFS) ||
               (ofs == scc_pkg::MODE_OFS) || (ofs == scc_pkg::TXDATA_OFS) ||
               (ofs == scc_pkg::RXDATA_OFS);
  endfunction

  scc_sync u_sync
  (
    .clock   (clock),
    .nrst    (nrst),
    .pinIn   (serialClkIn),
    .syncOut (runClk)
  );

  scc_clk_out u_clk_out
  (
    .clock     (clock),
    .nrst      (nrst),
    .cardMode  (state.mode[scc_pkg::CARD_MODE_SELECT]),
    .blockMode (state.mode[scc_pkg::BLOCK_OUTPUT_MODE]),
    .clockSel  (state.ctrl[scc_pkg::CLOCK_SEL_HI:scc_pkg::CLOCK_SEL_LO]),
    .runClk    (runClk),
    .pinOut    (sckOut),
    .pinOe     (sckOe)
  );

  always_comb
  begin
    logic       doWrite;
    logic       doRead;
    logic [7:0] clearMask;
    logic       rxOk;
    doWrite   = 1'b0;
    doRead    = 1'b0;
    clearMask = 8'h00;
    rxOk      = 1'b0;
    next_state = state;

    // Address and data are taken in either order and held until both exist.
    if (awvalid && state.awReady)
    begin
      next_state.awHave = 1'b1;
      next_state.awAddr = {awaddr[4:2], 2'h0};
    end
    if (wvalid && state.wReady)
    begin
      next_state.wHave = 1'b1;
      next_state.wData = wdata[7:0];
      next_state.wLane = wstrb[0];
    end
    if (bready && state.bValid)
      next_state.bValid = 1'b0;
    if (state.awHave && state.wHave && !state.bValid)
    begin
      doWrite           = 1'b1;
      next_state.awHave = 1'b0;
      next_state.wHave  = 1'b0;
      next_state.bValid = 1'b1;
      next_state.bResp  = isMapped(state.awAddr) ? scc_pkg::RESP_OKAY : scc_pkg::RESP_SLVERR;
    end

    // Register writes; a cleared lane leaves the register alone.
    if (doWrite && state.wLane)
    begin
      case (state.awAddr)
        scc_pkg::CTRL_OFS:   next_state.ctrl   = state.wData;
        scc_pkg::MODE_OFS:   next_state.mode   = state.wData[2:0];
        scc_pkg::TXDATA_OFS: next_state.txHold = state.wData;
        scc_pkg::STATUS_OFS: clearMask = ~state.wData & state.seen & scc_pkg::FLAG_MASK;
        default:             clearMask = 8'h00;
      endcase
    end

    // A flag must be read as 1 again before another clear takes effect.
    next_state.flags = state.flags & ~clearMask;
    next_state.seen  = state.seen & ~clearMask;
    if (engineTxWrite)
    begin
      next_state.txHold = engineTxData;
      next_state.flags[scc_pkg::TX_HOLDING_EMPTY] = 1'b0;
    end
    if (engineRxRead)
      next_state.flags[scc_pkg::RX_HOLDING_FULL] = 1'b0;

    // Sets come after clears, so an event in the clearing cycle is kept.
    if (!state.ctrl[scc_pkg::TX_ENABLE_BIT] || txLoad)
      next_state.flags[scc_pkg::TX_HOLDING_EMPTY] = 1'b1;
    if (rxDone && state.ctrl[scc_pkg::RX_ENABLE_BIT])
    begin
      rxOk = !rxParityErr && !rxFrameErr;
      if (state.flags[scc_pkg::RX_HOLDING_FULL])
        next_state.flags[scc_pkg::OVERRUN_FAULT] = 1'b1;
      else if (rxOk)
      begin
        next_state.rxHold = rxData;
        next_state.flags[scc_pkg::RX_HOLDING_FULL] = 1'b1;
      end
      if (rxParityErr)
        next_state.flags[scc_pkg::PARITY_FAULT] = 1'b1;
      if (rxFrameErr)
        next_state.flags[scc_pkg::FRAME_FAULT] = 1'b1;
    end

    // Read channel; a status read arms the clear of each flag seen at 1.
    if (rready && state.rValid)
      next_state.rValid = 1'b0;
    if (arvalid && state.arReady)
    begin
      doRead            = 1'b1;
      next_state.rValid = 1'b1;
      next_state.rResp  = isMapped({araddr[4:2], 2'h0}) ? scc_pkg::RESP_OKAY : scc_pkg::RESP_SLVERR;
    end
    if (doRead)
    begin
      case ({araddr[4:2], 2'h0})
        scc_pkg::CTRL_OFS:   next_state.rData = state.ctrl;
        scc_pkg::MODE_OFS:   next_state.rData = {5'h00, state.mode};
        scc_pkg::TXDATA_OFS: next_state.rData = state.txHold;
        scc_pkg::RXDATA_OFS: next_state.rData = state.rxHold;
        scc_pkg::STATUS_OFS:
        begin
          next_state.rData = state.flags & scc_pkg::FLAG_MASK;
          next_state.seen  = next_state.seen | (state.flags & scc_pkg::FLAG_MASK);
        end
        default:             next_state.rData = 8'h00;
      endcase
    end

    // Ready flags are registered so every bus output comes from a flip-flop.
    next_state.awReady = !next_state.awHave && !doWrite;
    next_state.wReady  = !next_state.wHave && !doWrite;
    next_state.arReady = !next_state.rValid;

    // Interrupt requests follow the new flag values and enables.
    next_state.txIrq = next_state.flags[scc_pkg::TX_HOLDING_EMPTY] &&
                       next_state.ctrl[scc_pkg::TX_EMPTY_IRQ_ENABLE];
    next_state.rxIrq = next_state.flags[scc_pkg::RX_HOLDING_FULL] &&
                       next_state.ctrl[scc_pkg::RX_IRQ_ENABLE];
    next_state.faultIrq = (next_state.flags[scc_pkg::OVERRUN_FAULT] ||
                           next_state.flags[scc_pkg::FRAME_FAULT] ||
                           next_state.flags[scc_pkg::PARITY_FAULT]) &&
                          next_state.ctrl[scc_pkg::RX_IRQ_ENABLE];
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state         <= '0;
      state.ctrl    <= scc_pkg::CTRL_RESET;
      state.mode    <= scc_pkg::MODE_RESET;
      state.flags   <= scc_pkg::STATUS_RESET;
      state.awReady <= 1'b1;
      state.wReady  <= 1'b1;
      state.arReady <= 1'b1;
    end
    else
      state <= next_state;
  end

  // Outputs come straight from state flip-flops.
  assign awready    = state.awReady;
  assign wready     = state.wReady;
  assign bvalid     = state.bValid;
  assign bresp      = state.bResp;
  assign arready    = state.arReady;
  assign rvalid     = state.rValid;
  assign rdata      = {24'h000000, state.rData};
  assign rresp      = state.rResp;
  assign txEnable   = state.ctrl[scc_pkg::TX_ENABLE_BIT];
  assign rxEnable   = state.ctrl[scc_pkg::RX_ENABLE_BIT];
  assign txData     = state.txHold;
  assign txEmptyIrq = state.txIrq;
  assign rxFullIrq  = state.rxIrq;
  assign rxFaultIrq = state.faultIrq;

endmodule

// ===== tb/scc_peer_model.sv
// Serial peer: runs a frame on request and acts as both shift engines.
// Assumes the bench raises go for one cycle while busy is low.
`timescale 1ns/1ps
module scc_peer_model
(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       nrst,
  // Bench request.
  input  wire logic       go,
  input  wire logic [3:0] bits,
  input  wire logic [7:0] charIn,
  input  wire logic [1:0] errIn,
  output logic            busy,
  // Device side.
  input  wire logic       txEnable,
  output logic            serialClk,
  output logic            txLoad,
  output logic            rxDone,
  output logic [7:0]      rxData,
  output logic            rxParityErr,
  output logic            rxFrameErr
);
  logic [7:0] cnt;
  // The serial clock stands low between frames and stale data is inverted.
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      {busy, serialClk, txLoad, rxDone, rxParityErr, rxFrameErr, cnt, rxData} <= '0;
    else
    begin
      txLoad <= 1'b0;
      rxDone <= 1'b0;
      if (rxDone)
        {rxParityErr, rxFrameErr, rxData} <= ~{rxParityErr, rxFrameErr, rxData};
      if (go && !busy)
      begin
        busy <= 1'b1;
        cnt  <= {bits, 4'h0};
      end
      else if (busy)
      begin
        cnt <= cnt - 8'h01;
        if (cnt[2:0] == 3'h0)
          serialClk <= ~serialClk;
        if (cnt == 8'h01)
        begin
          busy   <= 1'b0;
          txLoad <= txEnable;
          rxDone <= 1'b1;
          {rxParityErr, rxFrameErr, rxData} <= {errIn, charIn};
        end
      end
    end
endmodule

// ===== tb/scc_card_ctrl_asserts.sv
// Checker of the serial channel control block, bound to its top module.
// Assumes one clock domain with asynchronous active-low reset.
`timescale 1ns/1ps
module scc_card_ctrl_asserts
(
  // Clock and reset.
  input wire logic       clock,
  input wire logic       nrst,
  // Read channel.
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic       rready,
  // Engines.
  input wire logic       txEnable,
  input wire logic [7:0] txData,
  input wire logic       txLoad,
  input wire logic       rxEnable,
  input wire logic       rxDone,
  input wire logic       rxParityErr,
  input wire logic       rxFrameErr,
  input wire logic       engineTxWrite,
  input wire logic [7:0] engineTxData,
  input wire logic       engineRxRead,
  // Interrupts.
  input wire logic       txEmptyIrq,
  input wire logic       rxFullIrq,
  input wire logic       rxFaultIrq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_rans; arvalid && arready |=> rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read not answered");
  property p_rhold; rvalid && !rready |=> rvalid; endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_txclr; engineTxWrite && txEnable && !txLoad |=> !txEmptyIrq || !txEnable; endproperty
  a_txclr: assert property (p_txclr) else $error("tx empty not cleared");
  property p_txdat; engineTxWrite |=> txData == $past(engineTxData); endproperty
  a_txdat: assert property (p_txdat) else $error("tx holding not written");
  property p_rxclr; engineRxRead && !rxDone |=> !rxFullIrq; endproperty
  a_rxclr: assert property (p_rxclr) else $error("rx full not cleared");
  property p_ovr; rxDone && rxEnable && rxFullIrq && !engineRxRead |=> rxFaultIrq; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");
  property p_rxset;
    rxDone && rxEnable && rxFaultIrq && !rxParityErr && !rxFrameErr && !engineRxRead
      |=> rxFullIrq;
  endproperty
  a_rxset: assert property (p_rxset) else $error("rx full not set");
  property p_rxoff; !rxEnable && !rxFullIrq && rxFaultIrq |=> !rxFullIrq; endproperty
  a_rxoff: assert property (p_rxoff) else $error("reception while disabled");
  c_ovr: cover property (rxFaultIrq && rxFullIrq);
  c_load: cover property (txLoad && txEnable);
  c_eng: cover property (engineRxRead && rxFullIrq);
endmodule
bind scc_card_ctrl scc_card_ctrl_asserts i_scc_card_ctrl_asserts (.clock, .nrst, .arvalid,
  .arready, .rvalid, .rready, .txEnable, .txData, .txLoad, .rxEnable, .rxDone, .rxParityErr,
  .rxFrameErr, .engineTxWrite, .engineTxData, .engineRxRead, .txEmptyIrq, .rxFullIrq,
  .rxFaultIrq);

// ===== tb/tb_sci_card_mode_ctrl_status.sv
// Self-checking bench of the serial channel control block with a serial peer.
// Assumes registered bus outputs, so values read after an edge are pre-edge.
`timescale 1ns/1ps
module tb_sci_card_mode_ctrl_status;
  logic clock = 1'b0, nrst = 1'b0, go = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic engineTxWrite = 1'b0, engineRxRead = 1'b0;
  logic [4:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [7:0]  engineTxData = '0, charIn = '0, txData, rxData;
  logic [3:0]  bits = '0;
  logic [1:0]  errIn = '0, bresp, rresp;
  logic [2:0]  dly = '0;
  logic awready, wready, bvalid, arready, rvalid, txEnable, txLoad, rxEnable, rxDone;
  logic rxParityErr, rxFrameErr, txEmptyIrq, rxFullIrq, rxFaultIrq, serialClk, sckOut;
  logic sckOe, busy;
  int   n_errors = 0, comparisons = 0;
  scc_card_ctrl i_scc_card_ctrl (.clock, .nrst, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .txEnable, .txData, .txLoad, .rxEnable, .rxDone,
    .rxData, .rxParityErr, .rxFrameErr, .engineTxWrite, .engineTxData, .engineRxRead,
    .txEmptyIrq, .rxFullIrq, .rxFaultIrq, .serialClkIn(serialClk), .sckOut, .sckOe);
  scc_peer_model i_scc_peer_model (.clock, .nrst, .go, .bits, .charIn, .errIn, .busy,
    .txEnable, .serialClk, .txLoad, .rxDone, .rxData, .rxParityErr, .rxFrameErr);
  always #5 clock = ~clock;
  always @(posedge clock) dly <= {dly[1:0], serialClk};
  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic to(input int i);
    if (i >= 300)
    begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    int i;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 300; i++)
    begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    to(i);
    cmp(bresp, scc_pkg::RESP_OKAY);
    repeat (2) @(posedge clock);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 300; i++)
    begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    to(i);
  endtask
  task automatic chk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    cmp(d, e);
    cmp(r, scc_pkg::RESP_OKAY);
  endtask
  task automatic eng(input logic r, input logic [7:0] d);
    engineTxData  <= d;
    engineTxWrite <= !r;
    engineRxRead  <= r;
    @(posedge clock);
    {engineTxWrite, engineRxRead} <= 2'h0;
    repeat (2) @(posedge clock);
  endtask
  task automatic frame(input logic [3:0] b, input logic [7:0] c, input logic [1:0] e);
    int i;
    bits   <= b;
    charIn <= c;
    errIn  <= e;
    go     <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    for (i = 0; i < 300 && (busy || i == 0); i++) @(posedge clock);
    to(i);
    repeat (2) @(posedge clock);
  endtask
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    chk(scc_pkg::STATUS_OFS, 32'h80);
    cmp({txEmptyIrq, rxFullIrq, rxFaultIrq, txEnable, rxEnable, sckOe}, 6'h00);
    chk(scc_pkg::CTRL_OFS, 32'h00);
    rd(5'h14, d, r);
    cmp(r, scc_pkg::RESP_SLVERR);
  endtask
  task automatic t_tx();
    wr(scc_pkg::CTRL_OFS, 32'he0);
    cmp(txEnable, 1'b1);
    cmp(txEmptyIrq, 1'b1);
    eng(1'b0, 8'h5a);
    cmp(txEmptyIrq, 1'b0);
    cmp(txData, 8'h5a);
    frame(4'h1, 8'h00, 2'h0);
    cmp(txEmptyIrq, 1'b1);
    chk(scc_pkg::STATUS_OFS, 32'h80);
    wr(scc_pkg::STATUS_OFS, 32'h00);
    cmp(txEmptyIrq, 1'b0);
    wr(scc_pkg::CTRL_OFS, 32'h80);
    cmp(txEmptyIrq, 1'b1);
    wr(scc_pkg::CTRL_OFS, 32'h00);
    cmp(txEmptyIrq, 1'b0);
  endtask
  task automatic t_rx();
    wr(scc_pkg::CTRL_OFS, 32'h50);
    cmp(rxEnable, 1'b1);
    frame(4'h1, 8'h3c, 2'h0);
    cmp(rxFullIrq, 1'b1);
    chk(scc_pkg::RXDATA_OFS, 32'h3c);
    wr(scc_pkg::STATUS_OFS, 32'h00);
    cmp(rxFullIrq, 1'b1);
    frame(4'h1, 8'h11, 2'h0);
    cmp(rxFaultIrq, 1'b1);
    chk(scc_pkg::RXDATA_OFS, 32'h3c);
    chk(scc_pkg::STATUS_OFS, 32'he0);
    wr(scc_pkg::STATUS_OFS, 32'hff);
    chk(scc_pkg::STATUS_OFS, 32'he0);
    wr(scc_pkg::CTRL_OFS, 32'h40);
    cmp(rxFullIrq, 1'b1);
    wr(scc_pkg::CTRL_OFS, 32'h00);
    cmp(rxFullIrq | rxFaultIrq, 1'b0);
    wr(scc_pkg::CTRL_OFS, 32'h40);
    eng(1'b1, 8'h00);
    cmp(rxFullIrq, 1'b0);
    frame(4'h1, 8'h22, 2'h0);
    cmp(rxFullIrq, 1'b0);
    chk(scc_pkg::STATUS_OFS, 32'ha0);
    wr(scc_pkg::STATUS_OFS, 32'h00);
    cmp(rxFaultIrq, 1'b0);
    wr(scc_pkg::CTRL_OFS, 32'h50);
    frame(4'h1, 8'h33, 2'h2);
    cmp({rxFaultIrq, rxFullIrq}, 2'h2);
    frame(4'h1, 8'h44, 2'h0);
    cmp(rxFullIrq, 1'b1);
    chk(scc_pkg::RXDATA_OFS, 32'h44);
  endtask
  task automatic t_pin();
    int m, s, k;
    for (m = 0; m < 2; m++)
      for (s = 0; s < 4; s++)
      begin
        bits <= 4'h2;
        go   <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        wr(scc_pkg::MODE_OFS, 32'(2 * m + 1));
        wr(scc_pkg::CTRL_OFS, 32'(s));
        for (k = 0; k < 24; k++)
        begin
          @(posedge clock);
          cmp(sckOe, m == 1 || s == 1);
          if (m == 1 || s == 1)
            cmp(sckOut, s[0] ? dly[2] : s[1]);
        end
      end
  endtask
  initial
  begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_reset();
    t_tx();
    t_rx();
    t_pin();
    stop_test();
  end
endmodule
